//--- design/ssf_pkg.sv
// Shared constants and types for the serial status flag block.
package ssf_pkg;
    // ==================================================
    // Register byte offsets.
    localparam logic [7:0] OFF_STATUS  = 8'h00;
    localparam logic [7:0] OFF_CONTROL = 8'h04;
    localparam logic [7:0] OFF_TX_DATA = 8'h08;
    localparam logic [7:0] OFF_RX_DATA = 8'h0c;
    // ==================================================
    // Status bit positions and reset value.
    localparam int ST_TX_EMPTY = 7;
    localparam int ST_RX_FULL  = 6;
    localparam int ST_OVERRUN  = 5;
    localparam int ST_FRAMING  = 4;
    localparam int ST_PARITY   = 3;
    localparam int ST_TX_DONE  = 2;
    localparam int ST_MP_IN    = 1;
    localparam int ST_MP_OUT   = 0;
    localparam logic [7:0] STATUS_RESET = 8'h84;
    // ==================================================
    // Control bit positions and reset value.
    localparam int CT_TX_IE = 7;
    localparam int CT_RX_IE = 6;
    localparam int CT_TE   = 5;
    localparam int CT_RE   = 4;
    localparam int CT_SYNC = 3;
    localparam int CT_MP   = 2;
    localparam int CT_PEN  = 1;
    localparam int CT_ODD  = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // ==================================================
    // Completed reception handed over by the receive shifter.
    typedef struct packed {
        logic       done;
        logic [7:0] data;
        logic       stop;
        logic       parity;
    } ssf_rx_evt_t;
endpackage

//--- design/ssf_rx_check.sv
// Error checks on a completed received character.
`timescale 1ns/1ps
module ssf_rx_check (
    input  ssf_pkg::ssf_rx_evt_t evt,
    input  wire logic            sync_mode,
    input  wire logic            parity_en,
    input  wire logic            parity_odd,
    output logic                 frame_err,
    output logic                 parity_err
);
    // ==================================================
    // Only the first stop bit reaches this check.
    assign frame_err  = ~sync_mode & ~evt.stop;
    assign parity_err = ~sync_mode & parity_en & ((^evt.data ^ evt.parity) != parity_odd);
endmodule // ssf_rx_check

//--- design/ssf_status.sv
// Serial status flags with APB register access.
// Functional notes
// - Writing one never sets flags; zero clears only after reading one.
// - Transmit-done and received multiprocessor bit ignore writes.
// - Status resets to 0x84 on reset and standby.
// - Transmit-empty clears by armed zero write or DMA data write.
// - Transmit-empty sets on reset, transmit disabled, or shifter load.
// - Receive-full sets on error-free reception with data copied.
// - Receive-full clears on reset, armed zero write, or DMA read.
// - Receive data and full flag hold on overrun, while error flags are set, and on receive disable.
// - Overrun sets on reception while full; new character dropped.
// - Overrun halts reception, and transmission in synchronous mode.
// - Framing error sets when first stop bit is zero.
// - Framing error copies data, leaves full clear, halts reception.
// - Parity error sets on mismatch with even or odd selection.
// - Parity error copies data, leaves full clear, halts reception.
// - Error flags clear on reset, standby or armed zero write only.
// - Transmit-done sets on reset, transmit disabled, or last bit while empty.
// - Transmit-done clears together with transmit-empty.
// - Multiprocessor bit appended only in asynchronous multiprocessor transmit.
// - Transmit interrupt follows transmit-empty and its enable.
// - Receive and error interrupts follow flags and receive interrupt enable.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
module ssf_status (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic            module_stop,
    input  wire logic            tx_shift_load,
    input  wire logic            tx_last_bit,
    input  ssf_pkg::ssf_rx_evt_t rx_evt,
    input  wire logic            dma_tx_write,
    input  wire logic [7:0]      dma_tx_data,
    input  wire logic            dma_rx_read,
    output logic [7:0]           tx_data_holding,
    output logic                 tx_buffer_empty,
    output logic                 tx_allow,
    output logic                 tx_mp_append,
    output logic                 tx_mp_value,
    output logic [7:0]           rx_data_holding,
    output logic                 rx_allow,
    output logic                 tx_empty_irq,
    output logic                 rx_full_irq,
    output logic                 rx_error_irq
);
    // ==================================================
    // Register state.
    logic [7:0] ctrl_reg;
    logic [7:0] txd_reg;
    logic [7:0] rxd_reg;
    logic       txe_reg, rxf_reg, ovr_reg, frm_reg, par_reg, tdn_reg, mpo_reg;
    logic [4:0] armed_reg;
    logic [31:0] prdata_reg;
    logic       pready_reg, pslverr_reg;
    logic       txa_reg, rxa_reg, mpa_reg, txq_reg, rxq_reg, erq_reg;
    logic       txe_next, rxf_next, ovr_next, frm_next, par_next, tdn_next;
    // ==================================================
    // Bus decode.
    wire        setup    = psel & ~penable;
    wire        access   = psel & penable;
    wire        wr       = access & pwrite;
    wire        rd       = access & ~pwrite;
    wire        sel_st   = paddr == ssf_pkg::OFF_STATUS;
    wire        sel_ct   = paddr == ssf_pkg::OFF_CONTROL;
    wire        sel_tx   = paddr == ssf_pkg::OFF_TX_DATA;
    wire        sel_rx   = paddr == ssf_pkg::OFF_RX_DATA;
    wire        mapped   = sel_st | sel_ct | sel_tx | sel_rx;
    wire        st_wr    = wr & sel_st;
    wire [7:0]  status   = {txe_reg, rxf_reg, ovr_reg, frm_reg, par_reg, tdn_reg,
                            1'b0, mpo_reg};
    wire [7:0]  rd_mux   = sel_st ? status : sel_ct ? ctrl_reg :
                           sel_tx ? txd_reg : sel_rx ? rxd_reg : 8'h00;
    // ==================================================
    // Control fields.
    wire        tx_ie    = ctrl_reg[ssf_pkg::CT_TX_IE];
    wire        rx_ie    = ctrl_reg[ssf_pkg::CT_RX_IE];
    wire        te       = ctrl_reg[ssf_pkg::CT_TE];
    wire        re       = ctrl_reg[ssf_pkg::CT_RE];
    wire        sync_m   = ctrl_reg[ssf_pkg::CT_SYNC];
    // ==================================================
    // Clear strobes from a zero write to a flag that was read as one.
    wire        clr_txe  = st_wr & armed_reg[4] & ~pwdata[ssf_pkg::ST_TX_EMPTY];
    wire        clr_rxf  = st_wr & armed_reg[3] & ~pwdata[ssf_pkg::ST_RX_FULL];
    wire        clr_ovr  = st_wr & armed_reg[2] & ~pwdata[ssf_pkg::ST_OVERRUN];
    wire        clr_frm  = st_wr & armed_reg[1] & ~pwdata[ssf_pkg::ST_FRAMING];
    wire        clr_par  = st_wr & armed_reg[0] & ~pwdata[ssf_pkg::ST_PARITY];
    wire        tx_clr   = clr_txe | dma_tx_write;
    // ==================================================
    // Reception outcome.
    logic       fe, pe;
    ssf_rx_check u_chk (
        .evt        (rx_evt),
        .sync_mode  (sync_m),
        .parity_en  (ctrl_reg[ssf_pkg::CT_PEN]),
        .parity_odd (ctrl_reg[ssf_pkg::CT_ODD]),
        .frame_err  (fe),
        .parity_err (pe)
    );
    wire        rx_halt  = ovr_reg | frm_reg | par_reg;
    wire        rx_ok    = rx_evt.done & re & ~rx_halt;
    wire        rx_ovr   = rx_ok & rxf_reg;
    wire        rx_err   = rx_ok & ~rxf_reg & (fe | pe);
    wire        rx_good  = rx_ok & ~rxf_reg & ~fe & ~pe;
    wire        rx_copy  = rx_err | rx_good;
    // ==================================================
    // Flag next values; a hardware set wins over a software clear.
    assign txe_next = ~te | tx_shift_load | (txe_reg & ~tx_clr);
    assign tdn_next = ~te | (tx_last_bit & txe_reg) | (tdn_reg & ~tx_clr);
    assign rxf_next = rx_good | (rxf_reg & ~clr_rxf & ~dma_rx_read);
    assign ovr_next = rx_ovr | (ovr_reg & ~clr_ovr);
    assign frm_next = (rx_err & fe) | (frm_reg & ~clr_frm);
    assign par_next = (rx_err & pe) | (par_reg & ~clr_par);
    // ==================================================
    // APB responses; every access completes with no wait state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= 1'b1;
            if (setup) begin
                prdata_reg  <= {24'h00_0000, rd_mux};
                pslverr_reg <= ~mapped;
            end
        end
    end
    // ==================================================
    // Control and data holding registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= ssf_pkg::CONTROL_RESET;
            txd_reg  <= 8'h00;
            rxd_reg  <= 8'h00;
        end else begin
            if (module_stop) begin
                ctrl_reg <= ssf_pkg::CONTROL_RESET;
            end else if (wr & sel_ct) begin
                ctrl_reg <= pwdata[7:0];
            end
            if (dma_tx_write) begin
                txd_reg <= dma_tx_data;
            end else if (wr & sel_tx) begin
                txd_reg <= pwdata[7:0];
            end
            if (rx_copy) begin
                rxd_reg <= rx_evt.data;
            end
        end
    end
    // ==================================================
    // Status flags and read arming.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {txe_reg, rxf_reg, ovr_reg, frm_reg, par_reg, tdn_reg} <= 6'h21;
            mpo_reg   <= 1'b0;
            armed_reg <= 5'h00;
        end else if (module_stop) begin
            {txe_reg, rxf_reg, ovr_reg, frm_reg, par_reg, tdn_reg} <= 6'h21;
            mpo_reg   <= 1'b0;
            armed_reg <= 5'h00;
        end else begin
            txe_reg <= txe_next;
            rxf_reg <= rxf_next;
            ovr_reg <= ovr_next;
            frm_reg <= frm_next;
            par_reg <= par_next;
            tdn_reg <= tdn_next;
            if (st_wr) begin
                mpo_reg   <= pwdata[ssf_pkg::ST_MP_OUT];
                armed_reg <= 5'h00;
            end else if (rd & sel_st) begin
                // Only flags that the returned word showed as one become clearable.
                armed_reg <= prdata_reg[7:3] & {txe_reg, rxf_reg, ovr_reg, frm_reg, par_reg};
            end
        end
    end
    // ==================================================
    // Registered outputs toward the shifters and the interrupt controller.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txa_reg <= 1'b0;
            rxa_reg <= 1'b0;
            mpa_reg <= 1'b0;
            txq_reg <= 1'b0;
            rxq_reg <= 1'b0;
            erq_reg <= 1'b0;
        end else begin
            txa_reg <= te & ~(sync_m & ovr_next);
            rxa_reg <= re & ~(ovr_next | frm_next | par_next);
            mpa_reg <= ~sync_m & ctrl_reg[ssf_pkg::CT_MP];
            txq_reg <= tx_ie & txe_next & ~module_stop;
            rxq_reg <= rx_ie & rxf_next & ~module_stop;
            erq_reg <= rx_ie & (ovr_next | frm_next | par_next) & ~module_stop;
        end
    end
    assign prdata          = prdata_reg;
    assign pready          = pready_reg;
    assign pslverr         = pslverr_reg;
    assign tx_data_holding = txd_reg;
    assign tx_buffer_empty = txe_reg;
    assign tx_allow        = txa_reg;
    assign tx_mp_append    = mpa_reg;
    assign tx_mp_value     = mpo_reg;
    assign rx_data_holding = rxd_reg;
    assign rx_allow        = rxa_reg;
    assign tx_empty_irq    = txq_reg;
    assign rx_full_irq     = rxq_reg;
    assign rx_error_irq    = erq_reg;
    // ==================================================
    // Assertions.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_no_set;
        st_wr & ~rxf_reg & ~rx_good |=> ~rxf_reg;
    endproperty
    a_no_set: assert property (p_no_set) else $error("write set rx full");
    property p_tx_done_ro;
        st_wr & te & ~dma_tx_write & tdn_reg & ~armed_reg[4] & ~module_stop |=> tdn_reg;
    endproperty
    a_tx_done_ro: assert property (p_tx_done_ro) else $error("write changed tx done");
    property p_stop_val;
        module_stop |=> status == ssf_pkg::STATUS_RESET;
    endproperty
    a_stop_val: assert property (p_stop_val) else $error("standby value wrong");
    property p_te_off;
        ~te & ~module_stop |=> txe_reg && tdn_reg;
    endproperty
    a_te_off: assert property (p_te_off) else $error("tx disabled flags");
    property p_rx_good;
        rx_good & ~module_stop |=> rxf_reg && rxd_reg == $past(rx_evt.data);
    endproperty
    a_rx_good: assert property (p_rx_good) else $error("rx full not set");
    property p_ovr;
        rx_ovr & ~module_stop |=> ovr_reg && $stable(rxd_reg) ##1 ~rx_allow;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun handling");
    property p_fer;
        rx_err & fe & ~module_stop |=> frm_reg && ~rxf_reg;
    endproperty
    a_fer: assert property (p_fer) else $error("framing handling");
    property p_halt;
        rx_halt & ~module_stop |=> $stable(rxd_reg);
    endproperty
    a_halt: assert property (p_halt) else $error("reception not halted");
    property p_txi;
        tx_ie & txe_reg & ~tx_clr & ~module_stop |=> tx_empty_irq;
    endproperty
    a_txi: assert property (p_txi) else $error("tx irq missing");
    c_good: cover property (rx_good ##1 dma_rx_read);
    c_ovr:  cover property (rx_ovr);
    c_tx_done: cover property (tx_last_bit & txe_reg ##1 tdn_reg);
endmodule // ssf_status

//--- dv/ssf_far_end.sv
// Far-end shifter model that hands events to the status block.
`timescale 1ns/1ps
module ssf_far_end (
    input  wire logic            pclk,
    output ssf_pkg::ssf_rx_evt_t rx_evt,
    output logic                 tx_shift_load,
    output logic                 tx_last_bit
);
    initial begin
        rx_evt = '0;
        tx_shift_load = 1'b0;
        tx_last_bit = 1'b0;
    end
    // Finished character as a one-cycle pulse; the lines go stale after it.
    task automatic rx_char(input logic [7:0] d, input logic stp, input logic par);
        @(posedge pclk);
        rx_evt <= '{done: 1'b1, data: d, stop: stp, parity: par};
        @(posedge pclk);
        rx_evt <= '{done: 1'b0, data: ~d, stop: ~stp, parity: ~par};
    endtask
    // One shifter event: a load from holding or the last bit sent.
    task automatic tx_evt(input logic last);
        @(posedge pclk);
        if (last) tx_last_bit <= 1'b1;
        else tx_shift_load <= 1'b1;
        @(posedge pclk);
        tx_shift_load <= 1'b0;
        tx_last_bit <= 1'b0;
    endtask
endmodule // ssf_far_end

//--- dv/tb_top.sv
// Self-checking bench for the serial status flag block.
`timescale 1ns/1ps
module tb_top;
    logic                 pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic                 pwrite = 1'b0, module_stop = 1'b0, dma_tx_write = 1'b0;
    logic                 dma_rx_read = 1'b0, pready, pslverr, tx_buffer_empty, tx_allow;
    logic                 tx_mp_append, tx_mp_value, rx_allow, tx_empty_irq, rx_full_irq;
    logic                 rx_error_irq, tx_shift_load, tx_last_bit, last_err;
    logic [7:0]           paddr = 8'h00, dma_tx_data = 8'h00, tx_data_holding, rx_data_holding;
    logic [31:0]          pwdata = 32'h0, prdata, q;
    ssf_pkg::ssf_rx_evt_t rx_evt;
    int                   error_cnt = 0, n_checks = 0;
    ssf_status i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .module_stop, .tx_shift_load, .tx_last_bit, .rx_evt, .dma_tx_write,
        .dma_tx_data, .dma_rx_read, .tx_data_holding, .tx_buffer_empty, .tx_allow,
        .tx_mp_append, .tx_mp_value, .rx_data_holding, .rx_allow, .tx_empty_irq,
        .rx_full_irq, .rx_error_irq);
    ssf_far_end i_far (.pclk, .rx_evt, .tx_shift_load, .tx_last_bit);
    always #12.5 pclk = ~pclk;
    // ==================================================
    // Bus cycles and comparisons.
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk1(1'b0, 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr_st(input logic [7:0] d);
        apb(1'b1, ssf_pkg::OFF_STATUS, d);
    endtask
    task automatic wr_ct(input logic [7:0] d);
        apb(1'b1, ssf_pkg::OFF_CONTROL, d);
    endtask
    // Received multiprocessor bit is masked out of every status compare.
    task automatic st_is(input logic [7:0] e);
        apb(1'b0, ssf_pkg::OFF_STATUS, 8'h00);
        chk8(q[7:0] & 8'hfd, e & 8'hfd);
    endtask
    task automatic settle();
        repeat (2) @(posedge pclk);
    endtask
    task automatic pulse(input int which, input logic [7:0] d);
        @(posedge pclk);
        if (which == 0) dma_tx_write <= 1'b1;
        else if (which == 1) dma_rx_read <= 1'b1;
        else module_stop <= 1'b1;
        dma_tx_data <= d;
        @(posedge pclk);
        dma_tx_write <= 1'b0;
        dma_rx_read <= 1'b0;
        module_stop <= 1'b0;
        dma_tx_data <= ~d;
    endtask
    // ==================================================
    // Scenarios.
    task automatic t_reset();
        st_is(8'h84);
        apb(1'b0, 8'h10, 8'h00);
        chk1(last_err, 1'b1);
        wr_st(8'hff);
        st_is(8'h85);
        wr_ct(8'h04);
        settle();
        chk1(tx_mp_append, 1'b1);
        chk1(tx_mp_value, 1'b1);
        wr_ct(8'h0c);
        settle();
        chk1(tx_mp_append, 1'b0);
        wr_st(8'h84);
    endtask
    task automatic t_tx();
        wr_ct(8'h20);
        wr_st(8'h00);
        st_is(8'h84);
        wr_st(8'h00);
        st_is(8'h00);
        i_far.tx_evt(1'b0);
        st_is(8'h80);
        i_far.tx_evt(1'b1);
        st_is(8'h84);
        pulse(0, 8'h5a);
        st_is(8'h00);
        chk8(tx_data_holding, 8'h5a);
        i_far.tx_evt(1'b1);
        wr_ct(8'ha0);
        settle();
        chk1(tx_empty_irq, 1'b0);
        st_is(8'h00);
        i_far.tx_evt(1'b0);
        settle();
        chk1(tx_empty_irq, 1'b1);
        wr_ct(8'h00);
        st_is(8'h84);
        chk1(tx_empty_irq, 1'b0);
    endtask
    task automatic t_rx();
        wr_ct(8'h78);
        settle();
        chk1(tx_allow, 1'b1);
        i_far.rx_char(8'h3c, 1'b1, 1'b0);
        st_is(8'hc4);
        chk8(rx_data_holding, 8'h3c);
        chk1(rx_full_irq, 1'b1);
        i_far.rx_char(8'ha5, 1'b1, 1'b0);
        st_is(8'he4);
        chk8(rx_data_holding, 8'h3c);
        chk1(rx_allow, 1'b0);
        chk1(tx_allow, 1'b0);
        chk1(rx_error_irq, 1'b1);
        wr_ct(8'h68);
        st_is(8'he4);
        wr_st(8'h84);
        st_is(8'h84);
        wr_ct(8'h50);
        i_far.rx_char(8'h11, 1'b1, 1'b0);
        st_is(8'hc4);
        pulse(1, 8'h00);
        st_is(8'h84);
        chk1(rx_full_irq, 1'b0);
    endtask
    task automatic t_err();
        i_far.rx_char(8'h77, 1'b0, 1'b0);
        st_is(8'h94);
        chk8(rx_data_holding, 8'h77);
        chk1(rx_allow, 1'b0);
        i_far.rx_char(8'h12, 1'b1, 1'b0);
        chk8(rx_data_holding, 8'h77);
        wr_st(8'h84);
        st_is(8'h84);
        wr_ct(8'h52);
        i_far.rx_char(8'h01, 1'b1, 1'b0);
        st_is(8'h8c);
        chk8(rx_data_holding, 8'h01);
        wr_st(8'h84);
        wr_ct(8'h53);
        i_far.rx_char(8'h02, 1'b1, 1'b0);
        st_is(8'hc4);
        pulse(2, 8'h00);
        st_is(8'h84);
        apb(1'b0, ssf_pkg::OFF_CONTROL, 8'h00);
        chk8(q[7:0], 8'h00);
    endtask
    // ==================================================
    // Sequence, watchdog and verdict.
    task automatic print_verdict();
        $display("Checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_tx();
        t_rx();
        t_err();
        print_verdict();
    end
    initial begin
        #100us;
        error_cnt++;
        print_verdict();
    end
endmodule // tb_top
